// ---- rtl/csac_cluster.sv ----
// Ten-cell arithmetic cluster with carry-select chain, cell registers and register port.
//
// Function
// - Each cell precomputes sums for carry zero, one.
// - Cluster carry picks chain; chain level picks sum.
// - Each chain carry-in selects its own carry-out.
// - Sum offered combinationally and through the register.
// - Counter enable, up/down come from cell inputs.
// - Sync clear and load act cluster-wide together.
// - Add/subtract select chooses operation while running.
// - Subtract inverts operand B, forces carry-in one unless cascade is on.
// - Add/subtract inverts B in every cell and drives the first carry unless cascade is on.
// - Both chain carries pass to next cell.
// - A chain may start at any cell.
// - Carry selection regenerated at cell five (every SEG_LEN cells).
// - Final carry-out forwarded as an ordinary output.
// - Chains extend by linking clusters vertically.
// - Preset loads logic high, no data inversion.
// - Clear wins over preset or load.
// - Two clears and one preset shared per cluster.
// - Enabled chip reset clears all cell registers, overrides everything.
// - Clock enable low holds the cell registers; clears, preset and chip reset still act.
// - Asynchronous load value is third data input.
`timescale 1ns/1ps
`default_nettype none

module csac_cluster #(
   parameter int NUM_CELLS = csac_pkg::NUM_CELLS_DEF,
   parameter int SEG_LEN   = csac_pkg::SEG_LEN_DEF
) (
   input  wire logic                   CLK_SYS_I,
   input  wire logic                   RST_I,
   input  wire logic [NUM_CELLS-1:0]   OPERAND_A_BIT_I,
   input  wire logic [NUM_CELLS-1:0]   OPERAND_B_BIT_I,
   input  wire logic [NUM_CELLS-1:0]   ASYNC_LOAD_VALUE_I,
   input  wire logic [NUM_CELLS-1:0]   COUNT_EN_I,
   input  wire logic [NUM_CELLS-1:0]   UP_DOWN_I,
   input  wire csac_pkg::csac_ctrl_s   CTRL_I,
   input  wire logic                   CARRY_CLUSTER_I,
   input  wire logic                   CHIP_WIDE_RESET_N_I,
   input  wire logic [3:0]             ADDR_I,
   input  wire logic [31:0]            WDATA_I,
   input  wire logic                   WR_STB_I,
   input  wire logic                   RD_STB_I,
   output logic      [31:0]            RDATA_O,
   output logic      [NUM_CELLS-1:0]   SUM_O,
   output logic      [NUM_CELLS-1:0]   REG_Q_O,
   output logic                        CARRY_CASCADE_O,
   output logic                        CARRY_REG_O
);

   // ==========================================================================
   // Elaboration checks
   // ==========================================================================
   // Sizes that the chain, the start index field or the register map cannot
   // serve are refused while the design is built, not when it runs.
   generate
      if (NUM_CELLS < 1 || NUM_CELLS > 16)
      begin : g_bad_cells
         $error("NUM_CELLS must lie between 1 and 16.");
      end
      if (SEG_LEN < 1 || SEG_LEN > NUM_CELLS)
      begin : g_bad_seg
         $error("SEG_LEN must lie between 1 and NUM_CELLS.");
      end
      else if ((NUM_CELLS % SEG_LEN) != 0)
      begin : g_bad_multiple
         $error("NUM_CELLS must be a multiple of SEG_LEN.");
      end
      if ((2 ** csac_pkg::START_W) < NUM_CELLS)
      begin : g_bad_start
         $error("The start index field cannot reach every cell.");
      end
   endgenerate

   // ==========================================================================
   // Configuration registers
   // ==========================================================================
   // The configuration word selects the chip reset option, counter mode,
   // preset or load behaviour, the cascade carry and the chain start cell.
   // It is meant to be written while the cluster is idle: changing the start
   // cell or the cascade source in mid-run changes every sum at once.
   // The clear select word picks, per cell, which shared clear it obeys.
   logic [7:0]            config_reg;
   logic [NUM_CELLS-1:0]  clr_sel_reg;
   logic [NUM_CELLS-1:0]  q_reg;
   logic [NUM_CELLS-1:0]  q_next;
   logic                  carry_reg;
   logic [31:0]           rdata_reg;

   wire                         wr_config  = WR_STB_I && (ADDR_I == csac_pkg::OFF_CONFIG);
   wire                         wr_clr_sel = WR_STB_I && (ADDR_I == csac_pkg::OFF_CLR_SEL);
   wire                         rst_opt_en = config_reg[csac_pkg::CFG_RST_EN];
   wire                         cnt_mode   = config_reg[csac_pkg::CFG_COUNTER];
   wire                         preset_md  = config_reg[csac_pkg::CFG_PRESET];
   wire                         cascade_en = config_reg[csac_pkg::CFG_CASCADE];
   wire [csac_pkg::START_W-1:0] start_idx  =
      config_reg[csac_pkg::CFG_START_LSB +: csac_pkg::START_W];

   // An enabled chip-wide reset is the strongest register control.
   wire chip_rst = rst_opt_en && !CHIP_WIDE_RESET_N_I;

   // The first carry of a chain is the add/subtract select, or the carry of
   // the cluster below when the chain continues from there.
   wire first_carry = cascade_en ? CARRY_CLUSTER_I : CTRL_I.addnsub;

   // ==========================================================================
   // Per-cell datapath and carry-select chain
   // ==========================================================================
   // Both chains restart with fixed carries at the start cell and at every
   // segment boundary, so only the segment selects lie on the long path.
   // Cells below the start cell compute values that nobody should use; a
   // user who starts a chain above cell zero must ignore their outputs.
   logic [NUM_CELLS-1:0] a_eff;
   logic [NUM_CELLS-1:0] b_eff;
   logic [NUM_CELLS-1:0] sum_zero;
   logic [NUM_CELLS-1:0] sum_one;
   logic [NUM_CELLS-1:0] carry_zero_chain_in;
   logic [NUM_CELLS-1:0] carry_one_chain_in;
   logic [NUM_CELLS-1:0] carry_zero_chain_out;
   logic [NUM_CELLS-1:0] carry_one_chain_out;
   logic [NUM_CELLS-1:0] chain_sel;
   logic [NUM_CELLS-1:0] chosen_in;
   logic [NUM_CELLS-1:0] chosen_out;
   logic [NUM_CELLS-1:0] sum_sel;
   logic [NUM_CELLS-1:0] async_clr;
   logic [NUM_CELLS-1:0] b_raw;

   genvar i;
   generate
      for (i = 0; i < NUM_CELLS; i++)
      begin : g_cell
         wire is_start = (int'(start_idx) == i);
         wire is_seg   = ((i % SEG_LEN) == 0);
         wire is_top   = is_start || is_seg;

         // Counting adds +1 at the chain start for up, or all ones for down.
         assign b_raw[i] = cnt_mode ? (UP_DOWN_I[i] ? is_start : 1'b1)
                                    : OPERAND_B_BIT_I[i];
         assign a_eff[i] = cnt_mode ? q_reg[i] : OPERAND_A_BIT_I[i];
         assign b_eff[i] = b_raw[i] ^ CTRL_I.addnsub;

         // Candidate sums for an incoming carry of zero and of one.
         assign sum_zero[i] = a_eff[i] ^ b_eff[i];
         assign sum_one[i]  = ~(a_eff[i] ^ b_eff[i]);

         if (i == 0)
         begin : g_first
            assign carry_zero_chain_in[i] = 1'b0;
            assign carry_one_chain_in[i]  = 1'b1;
            assign chain_sel[i]           = first_carry;
         end
         else
         begin : g_next
            // Chains restart at the chain start and at each regeneration point.
            assign carry_zero_chain_in[i] = is_top ? 1'b0 : carry_zero_chain_out[i-1];
            assign carry_one_chain_in[i]  = is_top ? 1'b1 : carry_one_chain_out[i-1];
            assign chain_sel[i] = is_start ? first_carry
                                : is_seg   ? chosen_out[i-1]
                                :            chain_sel[i-1];
         end

         // Each chain's carry-in picks between generate and propagate terms.
         assign carry_zero_chain_out[i] = carry_zero_chain_in[i] ? (a_eff[i] | b_eff[i])
                                                                 : (a_eff[i] & b_eff[i]);
         assign carry_one_chain_out[i]  = carry_one_chain_in[i]  ? (a_eff[i] | b_eff[i])
                                                                 : (a_eff[i] & b_eff[i]);
         assign chosen_in[i]  = chain_sel[i] ? carry_one_chain_in[i]  : carry_zero_chain_in[i];
         assign chosen_out[i] = chain_sel[i] ? carry_one_chain_out[i] : carry_zero_chain_out[i];
         assign sum_sel[i]    = chosen_in[i] ? sum_one[i] : sum_zero[i];

         // Each cell listens to one of the two shared clears.
         assign async_clr[i] = clr_sel_reg[i] ? CTRL_I.clr_two : CTRL_I.clr_one;

         // Register next value, strongest control first.
         // The two shared clears and the preset/load control act at the next clock edge
         // whatever the clock enable says, so that the flops keep constant
         // reset values; a pulse shorter than one clock is not seen.
         assign q_next[i] = chip_rst        ? 1'b0
                          : async_clr[i]    ? 1'b0
                          : CTRL_I.preset_load
                                            ? (preset_md ? 1'b1
                                                         : ASYNC_LOAD_VALUE_I[i])
                          : !CTRL_I.clk_ena ? q_reg[i]
                          : CTRL_I.sync_clear ? 1'b0
                          : CTRL_I.sync_load  ? ASYNC_LOAD_VALUE_I[i]
                          : (cnt_mode && !COUNT_EN_I[i]) ? q_reg[i]
                          : sum_sel[i];
      end
   endgenerate

   // ==========================================================================
   // Cell registers and final carry
   // ==========================================================================
   wire carry_final = chosen_out[NUM_CELLS-1];

   always_ff @(posedge CLK_SYS_I or posedge RST_I)
   begin
      if (RST_I)
      begin
         q_reg <= '0;
      end
      else
      begin
         q_reg <= q_next;
      end
   end

   // The final carry is kept in a flop so it can leave as a plain output.
   always_ff @(posedge CLK_SYS_I or posedge RST_I)
   begin
      if (RST_I)
      begin
         carry_reg <= 1'b0;
      end
      else
      begin
         carry_reg <= carry_final;
      end
   end

   // ==========================================================================
   // Register port
   // ==========================================================================
   // Writes to addresses outside the map fall through both decoders and
   // change nothing; the status word is read only.
   always_ff @(posedge CLK_SYS_I or posedge RST_I)
   begin
      if (RST_I)
      begin
         config_reg <= csac_pkg::CONFIG_RST;
      end
      else if (wr_config)
      begin
         config_reg <= WDATA_I[7:0];
      end
   end

   always_ff @(posedge CLK_SYS_I or posedge RST_I)
   begin
      if (RST_I)
      begin
         clr_sel_reg <= '0;
      end
      else if (wr_clr_sel)
      begin
         clr_sel_reg <= WDATA_I[NUM_CELLS-1:0];
      end
   end

   logic [31:0] status_word;
   logic [31:0] clr_sel_word;
   logic [31:0] rd_mux;

   always_comb
   begin
      status_word                      = 32'h0000_0000;
      status_word[NUM_CELLS-1:0]       = q_reg;
      status_word[csac_pkg::STS_CARRY] = carry_reg;
      clr_sel_word                     = 32'h0000_0000;
      clr_sel_word[NUM_CELLS-1:0]      = clr_sel_reg;
   end

   assign rd_mux = (ADDR_I == csac_pkg::OFF_CONFIG)  ? {24'h00_0000, config_reg}
                 : (ADDR_I == csac_pkg::OFF_CLR_SEL) ? clr_sel_word
                 : (ADDR_I == csac_pkg::OFF_STATUS)  ? status_word
                 :                                     32'h0000_0000;

   // Read data stands only in the cycle after the strobe.
   always_ff @(posedge CLK_SYS_I or posedge RST_I)
   begin
      if (RST_I)
      begin
         rdata_reg <= csac_pkg::RDATA_RST;
      end
      else
      begin
         rdata_reg <= RD_STB_I ? rd_mux : csac_pkg::RDATA_RST;
      end
   end

   // ==========================================================================
   // Outputs
   // ==========================================================================
   // The sum and the cascade carry bypass the cell registers on purpose, so a
   // plain adder needs no clock; whoever samples them must allow for the
   // full chain delay, including the carry arriving from the cluster below.
   assign RDATA_O         = rdata_reg;
   assign REG_Q_O         = q_reg;
   assign CARRY_REG_O     = carry_reg;
   assign SUM_O           = sum_sel;
   assign CARRY_CASCADE_O = carry_final;

endmodule

`default_nettype wire

// ---- rtl/csac_pkg.sv ----
// Shared constants and carrier types for the carry-select arithmetic cluster.
package csac_pkg;

   // ==========================================================================
   // Cluster geometry
   // ==========================================================================
   localparam int NUM_CELLS_DEF = 10;
   localparam int SEG_LEN_DEF   = 5;
   localparam int START_W       = 4;

   // ==========================================================================
   // Register map and field positions
   // ==========================================================================
   localparam int          ADDR_W        = 4;
   localparam logic [3:0]  OFF_CONFIG    = 4'h0;
   localparam logic [3:0]  OFF_CLR_SEL   = 4'h4;
   localparam logic [3:0]  OFF_STATUS    = 4'h8;
   localparam int          CFG_RST_EN    = 0;
   localparam int          CFG_COUNTER   = 1;
   localparam int          CFG_PRESET    = 2;
   localparam int          CFG_CASCADE   = 3;
   localparam int          CFG_START_LSB = 4;
   localparam int          STS_CARRY     = 16;
   localparam logic [7:0]  CONFIG_RST    = 8'h00;
   localparam logic [31:0] RDATA_RST     = 32'h0000_0000;

   // ==========================================================================
   // Cluster-wide control carrier
   // ==========================================================================
   typedef struct packed {
      logic addnsub;
      logic sync_clear;
      logic sync_load;
      logic clk_ena;
      logic clr_one;
      logic clr_two;
      logic preset_load;
   } csac_ctrl_s;

endpackage

// ---- verification/csac_cluster_asserts.sv ----
// Port-level checks on the arithmetic cluster's registers, carry and read port.
`timescale 1ns/1ps
`default_nettype none
module csac_cluster_asserts #(
   parameter int NUM_CELLS = 10
) (
   input wire logic                 CLK_SYS_I,
   input wire logic                 RST_I,
   input wire logic [NUM_CELLS-1:0] ASYNC_LOAD_VALUE_I,
   input wire csac_pkg::csac_ctrl_s CTRL_I,
   input wire logic                 CHIP_WIDE_RESET_N_I,
   input wire logic [3:0]           ADDR_I,
   input wire logic                 RD_STB_I,
   input wire logic [31:0]          RDATA_O,
   input wire logic [NUM_CELLS-1:0] REG_Q_O,
   input wire logic                 CARRY_CASCADE_O,
   input wire logic                 CARRY_REG_O
);
   default clocking cb @(posedge CLK_SYS_I);
   endclocking
   default disable iff (RST_I);
   // ==========================================================================
   // Helpers
   // ==========================================================================
   // No clear and no chip reset pending on this cycle.
   wire logic calm = !CTRL_I.clr_one && !CTRL_I.clr_two && CHIP_WIDE_RESET_N_I;
   wire logic run  = calm && !CTRL_I.preset_load && CTRL_I.clk_ena;
   sequence s_cleared;
      CTRL_I.clr_one && CTRL_I.clr_two;
   endsequence
   // ==========================================================================
   // Properties
   // ==========================================================================
   property p_clear_wins;
      CTRL_I.preset_load ##0 s_cleared |=> REG_Q_O == '0;
   endproperty
   property p_clear_hold;
      s_cleared [*2] |-> REG_Q_O == '0;
   endproperty
   property p_preset;
      CTRL_I.preset_load && calm |=> REG_Q_O == '1 || REG_Q_O == $past(ASYNC_LOAD_VALUE_I);
   endproperty
   property p_hold;
      calm && !CTRL_I.preset_load && !CTRL_I.clk_ena |=> $stable(REG_Q_O);
   endproperty
   property p_sync_clear;
      run && CTRL_I.sync_clear |=> REG_Q_O == '0;
   endproperty
   property p_sync_load;
      run && !CTRL_I.sync_clear && CTRL_I.sync_load |=> REG_Q_O == $past(ASYNC_LOAD_VALUE_I);
   endproperty
   property p_carry_reg;
      !$past(RST_I) |-> CARRY_REG_O == $past(CARRY_CASCADE_O);
   endproperty
   property p_rd_idle;
      !$past(RD_STB_I) |-> RDATA_O == '0;
   endproperty
   property p_unmapped;
      RD_STB_I && !(ADDR_I inside {4'h0, 4'h4, 4'h8}) |=> RDATA_O == '0;
   endproperty
   a_clear_wins: assert property (p_clear_wins)
      else $error("clear lost to preset");
   a_clear_hold: assert property (p_clear_hold)
      else $error("register not zero under clear");
   a_preset: assert property (p_preset)
      else $error("preset value wrong");
   a_hold: assert property (p_hold)
      else $error("register moved with clock enable low");
   a_sync_clear: assert property (p_sync_clear)
      else $error("sync clear missed");
   a_sync_load: assert property (p_sync_load)
      else $error("sync load value wrong");
   a_carry_reg: assert property (p_carry_reg)
      else $error("registered carry wrong");
   a_rd_idle: assert property (p_rd_idle)
      else $error("read data not idle");
   a_unmapped: assert property (p_unmapped)
      else $error("unmapped read not zero");
endmodule
bind csac_cluster csac_cluster_asserts #(.NUM_CELLS(NUM_CELLS)) u_chk (
   .CLK_SYS_I, .RST_I, .ASYNC_LOAD_VALUE_I, .CTRL_I, .CHIP_WIDE_RESET_N_I, .ADDR_I,
   .RD_STB_I, .RDATA_O, .REG_Q_O, .CARRY_CASCADE_O, .CARRY_REG_O
);
`default_nettype wire

// ---- verification/csac_lower_model.sv ----
// Model of the cluster below, supplying the cascade carry.
`timescale 1ns/1ps
`default_nettype none
module csac_lower_model (
   input  wire logic [9:0] a_i,
   input  wire logic [9:0] b_i,
   output logic            carry_o
);
   logic [10:0] sum_w;
   assign sum_w   = {1'b0, a_i} + {1'b0, b_i};
   assign carry_o = sum_w[10];
endmodule
`default_nettype wire

// ---- verification/testbench.sv ----
// Self-checking bench with a behavioural model of the cluster.
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic clk = 0, rst = 1, nr = 1, wr = 0, rd = 0, co, cr, lc;
   logic [9:0] a = 0, b = 0, d = 0, ce = 0, ud = 0, la = 0, lb = 0, s, q;
   logic [3:0] ad = 0;
   logic [31:0] wd = 0, rdat;
   csac_pkg::csac_ctrl_s c = '0;
   int err_count = 0, tests_run = 0, mq = 0, ecr = 0, ok = 0, cfg = 0, csel = 0, sd;
   int tab[5] = '{8'h00, 8'h05, 8'h08, 8'h50, 8'h02};
   initial forever #5 clk = ~clk;
   csac_lower_model u_low (.a_i(la), .b_i(lb), .carry_o(lc));
   csac_cluster uut (.CLK_SYS_I(clk), .RST_I(rst), .OPERAND_A_BIT_I(a), .OPERAND_B_BIT_I(b),
      .ASYNC_LOAD_VALUE_I(d), .COUNT_EN_I(ce), .UP_DOWN_I(ud), .CTRL_I(c),
      .CARRY_CLUSTER_I(lc), .CHIP_WIDE_RESET_N_I(nr), .ADDR_I(ad), .WDATA_I(wd),
      .WR_STB_I(wr), .RD_STB_I(rd), .RDATA_O(rdat), .SUM_O(s), .REG_Q_O(q),
      .CARRY_CASCADE_O(co), .CARRY_REG_O(cr));
   task automatic chk(input string k, input logic [31:0] g, input logic [31:0] e);
      tests_run++;
      if (g !== e)
      begin
         err_count++;
         $display("Error at %0t: %s got %h expected %h", $time, k, g, e);
      end
   endtask
   task complete_run;
      if (err_count == 0 && tests_run > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   // Selected sum over the live chain and its final carry.
   function automatic int add(output int cy);
      int st, op, bb, f;
      st = cfg[7:4];
      op = cfg[1] ? mq : a;
      bb = cfg[1] ? (ud[0] ? 1 << st : 10'h3FF) : b;
      bb = c.addnsub ? bb ^ 10'h3FF : bb;
      f = (op >> st) + (bb >> st) + (cfg[3] ? lc : c.addnsub);
      cy = (f >> (10 - st)) & 1;
      return (f << st) & 10'h3FF;
   endfunction
   function automatic int nxt(input int qv, input int sm);
      int r = 0;
      if (cfg[0] && !nr)
         return 0;
      for (int i = 0; i < 10; i++)
      begin
         if (csel[i] ? c.clr_two : c.clr_one)
            r[i] = 0;
         else if (c.preset_load)
            r[i] = cfg[2] | d[i];
         else if (!c.clk_ena)
            r[i] = qv[i];
         else if (c.sync_clear || c.sync_load)
            r[i] = !c.sync_clear && d[i];
         else if (cfg[1] && !ce[i])
            r[i] = qv[i];
         else
            r[i] = sm[i];
      end
      return r;
   endfunction
   task automatic step;
      int cy, sm, m;
      @(negedge clk);
      m = (10'h3FF << cfg[7:4]) & 10'h3FF;
      sm = add(cy);
      chk("sum", s & m, sm & m);
      chk("carry", co, cy);
      chk("reg", q & m, mq & m);
      if (ok)
         chk("creg", cr, ecr);
      ecr = cy;
      ok = 1;
      mq = nxt(mq, sm);
      @(posedge clk);
   endtask
   task automatic wrr(input logic [3:0] av, input int v);
      @(posedge clk);
      ad <= av;
      wd <= v;
      wr <= 1;
      @(posedge clk);
      wr <= 0;
      if (av == 4'h0)
         cfg = v;
      if (av == 4'h4)
         csel = v;
      ok = 0;
   endtask
   task automatic rdr(input logic [3:0] av, input int e);
      @(posedge clk);
      ad <= av;
      rd <= 1;
      @(posedge clk);
      rd <= 0;
      @(negedge clk);
      chk("rdata", rdat, e);
      ok = 0;
      @(posedge clk);
   endtask
   initial
   begin
      sd = $urandom(32'h325D7D6A);
      repeat (20) @(posedge clk);
      rst <= 0;
      for (int k = 0; k < 5; k++)
      begin
         c <= 7'h06;
         nr <= 1;
         step;
         step;
         c <= 7'h00;
         step;
         if (cfg[7:4] == 0)
            rdr(4'h8, (ecr << 16) | mq);
         wrr(4'h0, tab[k]);
         wrr(4'h4, $urandom & 10'h3FF);
         wrr(4'hC, 32'hFFFF_FFFF);
         rdr(4'h0, cfg);
         rdr(4'h4, csel);
         rdr(4'hC, 0);
         repeat (80)
         begin
            a <= 10'($urandom);
            b <= 10'($urandom);
            d <= 10'($urandom);
            ce <= 10'($urandom);
            la <= 10'($urandom);
            lb <= 10'($urandom);
            ud <= {10{1'($urandom)}};
            nr <= $urandom % 8 != 0;
            c <= ($urandom % 4 == 0) ? 7'($urandom)
                 : {1'($urandom), 1'b0, 1'($urandom % 4 == 0), 4'h8};
            step;
         end
      end
      complete_run;
   end
   initial
   begin
      #100000;
      err_count++;
      complete_run;
   end
endmodule
`default_nettype wire
